// [scm_sysctl.sv]
// Coprocessor transfer decoder, register file and MMU table walker
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
// Contract
// - Sixteen locations; 4, 11, 12, 14 reserved
// - Locations 0, 5, 13 select by op2
// - Location 9 selects lockdown or TCM by aux
// - Privileged only; move-to writes, move-from reads
// - Data-processing, load, store raise undefined
// - Recognise cond, 1110, coproc 15, bit4 one
// - Bits 19..16 pick target location
// - Bits 15..12 core register; program counter unpredictable
// - Op2 bits 7..5, aux bits 3..0
// - Virtual address modified by process identifier
// - First level: 4096 entries by bits 31..20
// - First level maps section or points table
// - Coarse: large/small; fine: also tiny
// - Sizes 1M, 64K/16K, 4K/1K, 1K
// - Sixteen domains gate permission use
// - Large and small pages: four subpage permissions
// - Check domain and permissions every access
// - Hit denied aborts; miss starts walk
// - Walk starts level one; pages need two
module scm_sysctl #(
  parameter logic [31:0] ID_CODE = 32'h00000001, // Arbitrary identity value
  parameter logic [31:0] CACHE_TYPE = 32'h00000000, // Cache type word
  parameter logic [31:0] TCM_STATUS = 32'h00000000 // TCM status word
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Synchronous reset
  input wire logic ce_i, // Clock enable
  input wire logic cp_valid_i, // Instruction pulse
  input wire logic [31:0] cp_instr_i, // Instruction word
  input wire logic [31:0] cp_wdata_i, // Core register value
  input wire logic cp_priv_i, // Core in privileged mode
  output logic cp_done_o, // Instruction answered
  output logic cp_undef_o, // Undefined instruction
  output logic [31:0] cp_rdata_o, // Read value
  input wire logic va_valid_i, // Translation request pulse
  input wire logic [31:0] va_i, // Virtual address
  input wire logic va_write_i, // Access is a write
  input wire logic va_fetch_i, // Access is a fetch
  input wire logic va_priv_i, // Access is privileged
  output logic xl_busy_o, // Translation in progress
  output logic xl_done_o, // Translation answered
  output logic xl_abort_o, // Access aborted
  output logic [31:0] xl_pa_o, // Physical address
  output logic mem_req_o, // Table fetch request
  output logic [31:0] mem_addr_o, // Table fetch address
  input wire logic [31:0] mem_rdata_i, // Fetched descriptor
  input wire logic mem_ack_i, // Fetch complete
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [31:0] wb_adr_i, // Wishbone address
  input wire logic [3:0] wb_sel_i, // Wishbone byte select
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o // Wishbone acknowledge
);
  logic cp_done_q, cp_undef_q, cp_en_q, wb_ack_q;
  logic [31:0] cp_rdata_q, wb_dat_q, rd_d, fsr_d;
  logic [31:0] ctrl_q, ttb_q, dac_q, dfsr_q, ifsr_q, far_q;
  logic [31:0] lock_q, tcm_q, tlblk_q, pid_q, ctx_q, test_q;
  logic [3:0] loc, aux_reg_field;
  logic [2:0] op2;
  logic xfer, take, ok, rd_op, wr_op, tlb_flush, mmu_on;
  scm_pkg::scm_state_type st_q;
  logic mem_req_q, xl_done_q, xl_abort_q, busy_q, fine_q;
  logic [31:0] mem_addr_q, xl_pa_q, mva_q;
  logic wr_q, fetch_q, priv_q;
  logic [3:0] l1dom_q;
  logic tlb_v_q;
  scm_pkg::scm_size_type tlb_sz_q;
  logic [31:0] tlb_tag_q, tlb_base_q;
  logic [3:0] tlb_dom_q;
  logic [7:0] tlb_ap_q;
  logic hit, dom_f, perm_f, deny, l1_ack, l2_ack, walk_f, answer;
  logic [1:0] dtype;

  // Range covered by one entry of the given size
  function automatic logic [31:0] mask_of(input scm_pkg::scm_size_type sz);
    unique case (sz)
      scm_pkg::SZ_SECTION: return scm_pkg::MASK_SEC;
      scm_pkg::SZ_LARGE: return scm_pkg::MASK_LARGE;
      scm_pkg::SZ_SMALL: return scm_pkg::MASK_SMALL;
      scm_pkg::SZ_TINY: return scm_pkg::MASK_TINY;
    endcase
  endfunction

  // Quarter of the page an address falls in
  function automatic logic [1:0] sub_of(input scm_pkg::scm_size_type sz,
                                        input logic [31:0] a);
    unique case (sz)
      scm_pkg::SZ_LARGE: return a[scm_pkg::LARGE_SUB_LO +: 2];
      scm_pkg::SZ_SMALL: return a[scm_pkg::SMALL_SUB_LO +: 2];
      default: return 2'h0;
    endcase
  endfunction

  // Instruction field decode
  assign loc = cp_instr_i[scm_pkg::CRN_HI:scm_pkg::CRN_LO];
  assign op2 = cp_instr_i[scm_pkg::OP2_HI:scm_pkg::OP2_LO];
  assign aux_reg_field = cp_instr_i[scm_pkg::CRM_HI:scm_pkg::CRM_LO];
  assign xfer = cp_instr_i[scm_pkg::COND_HI:scm_pkg::COND_LO] != scm_pkg::COND_EXT
    && cp_instr_i[scm_pkg::FIX_HI:scm_pkg::FIX_LO] == scm_pkg::FIX_XFER
    && cp_instr_i[scm_pkg::CPN_HI:scm_pkg::CPN_LO] == scm_pkg::CP_NUM
    && cp_instr_i[scm_pkg::XFER_BIT];
  assign take = ce_i && cp_valid_i;
  assign ok = xfer && cp_priv_i && cp_en_q;
  assign rd_op = take && ok && cp_instr_i[scm_pkg::DIR_BIT];
  assign wr_op = take && ok && !cp_instr_i[scm_pkg::DIR_BIT];
  assign tlb_flush = wr_op && loc == scm_pkg::LOC_TLBOP;
  assign mmu_on = ctrl_q[scm_pkg::CTRL_MMU];

  // Read selection per location
  always_comb begin
    rd_d = 32'h00000000;
    unique case (loc)
      scm_pkg::LOC_ID: begin
        unique case (op2)
          scm_pkg::OP2_ID: rd_d = ID_CODE;
          scm_pkg::OP2_CTYPE: rd_d = CACHE_TYPE;
          scm_pkg::OP2_TCM: rd_d = TCM_STATUS;
          default: rd_d = ID_CODE;
        endcase
      end
      scm_pkg::LOC_CTRL: rd_d = ctrl_q;
      scm_pkg::LOC_TTB: rd_d = ttb_q;
      scm_pkg::LOC_DAC: rd_d = dac_q;
      scm_pkg::LOC_FSR: rd_d = (op2 == scm_pkg::OP2_INSN) ? ifsr_q : dfsr_q;
      scm_pkg::LOC_FAR: rd_d = far_q;
      scm_pkg::LOC_LOCK: rd_d = (aux_reg_field == scm_pkg::CRM_TCM) ? tcm_q : lock_q;
      scm_pkg::LOC_TLBLK: rd_d = tlblk_q;
      scm_pkg::LOC_PID: rd_d = (op2 == scm_pkg::OP2_CTX) ? ctx_q : pid_q;
      scm_pkg::LOC_TEST: rd_d = test_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  // Writable coprocessor registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= scm_pkg::CTRL_RST;
      {ttb_q, dac_q, lock_q, tcm_q} <= '0;
      {tlblk_q, pid_q, ctx_q, test_q} <= '0;
    end else if (wr_op) begin
      unique case (loc)
        scm_pkg::LOC_CTRL: ctrl_q <= cp_wdata_i;
        scm_pkg::LOC_TTB: ttb_q <= cp_wdata_i;
        scm_pkg::LOC_DAC: dac_q <= cp_wdata_i;
        scm_pkg::LOC_LOCK: begin
          if (aux_reg_field == scm_pkg::CRM_TCM) begin
            tcm_q <= cp_wdata_i;
          end else begin
            lock_q <= cp_wdata_i;
          end
        end
        scm_pkg::LOC_TLBLK: tlblk_q <= cp_wdata_i;
        scm_pkg::LOC_PID: begin
          if (op2 == scm_pkg::OP2_CTX) begin
            ctx_q <= cp_wdata_i;
          end else begin
            pid_q <= cp_wdata_i;
          end
        end
        scm_pkg::LOC_TEST: test_q <= cp_wdata_i;
        default: ;
      endcase
    end
  end

  // Coprocessor answer one cycle after the instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cp_done_q <= 1'b0;
      cp_undef_q <= 1'b0;
      cp_rdata_q <= '0;
    end else if (ce_i) begin
      cp_done_q <= cp_valid_i;
      cp_undef_q <= cp_valid_i && !ok;
      cp_rdata_q <= rd_op ? rd_d : 32'h00000000;
    end
  end

  // Translation request capture with context switch mapping
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mva_q <= '0;
      {wr_q, fetch_q, priv_q} <= '0;
    end else if (ce_i && va_valid_i && !busy_q) begin
      mva_q <= va_i;
      if (va_i[31:scm_pkg::PID_LO] == '0) begin
        mva_q[31:scm_pkg::PID_LO] <= pid_q[31:scm_pkg::PID_LO];
      end
      {wr_q, fetch_q, priv_q} <= {va_write_i, va_fetch_i, va_priv_i};
    end
  end

  // Lookup and check against the cached entry
  assign hit = tlb_v_q && ((mva_q & mask_of(tlb_sz_q)) == tlb_tag_q);
  scm_access_check u_check (
    .dac_i(dac_q),
    .dom_i(tlb_dom_q),
    .ap_i(tlb_ap_q[{sub_of(tlb_sz_q, mva_q), 1'b0} +: 2]),
    .priv_i(priv_q),
    .write_i(wr_q),
    .dom_fault_o(dom_f),
    .perm_fault_o(perm_f)
  );
  assign deny = dom_f || perm_f;
  assign dtype = mem_rdata_i[1:0];
  assign l1_ack = ce_i && st_q == scm_pkg::ST_L1 && mem_ack_i;
  assign l2_ack = ce_i && st_q == scm_pkg::ST_L2 && mem_ack_i;
  assign walk_f = (l1_ack && dtype == scm_pkg::D_FAULT)
    || (l2_ack && (dtype == scm_pkg::D_FAULT
    || (!fine_q && dtype == scm_pkg::L2_TINY)));
  assign answer = (ce_i && st_q == scm_pkg::ST_LOOK && (!mmu_on || hit)) || walk_f;

  // Walk state machine and table fetch port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= scm_pkg::ST_IDLE;
      mem_req_q <= 1'b0;
      mem_addr_q <= '0;
      busy_q <= 1'b0;
      fine_q <= 1'b0;
      l1dom_q <= '0;
    end else if (ce_i) begin
      unique case (st_q)
        scm_pkg::ST_IDLE: begin
          if (va_valid_i) begin
            st_q <= scm_pkg::ST_LOOK;
            busy_q <= 1'b1;
          end
        end
        scm_pkg::ST_LOOK: begin
          if (!mmu_on || hit) begin
            st_q <= scm_pkg::ST_IDLE;
            busy_q <= 1'b0;
          end else begin
            st_q <= scm_pkg::ST_L1;
            mem_req_q <= 1'b1;
            mem_addr_q <= {ttb_q[31:scm_pkg::TTB_LO],
                           mva_q[31:scm_pkg::L1_IDX_LO], 2'b00};
          end
        end
        scm_pkg::ST_L1: begin
          if (mem_ack_i) begin
            l1dom_q <= mem_rdata_i[scm_pkg::DOM_HI:scm_pkg::DOM_LO];
            fine_q <= dtype == scm_pkg::L1_FINE;
            unique case (dtype)
              scm_pkg::L1_SECTION: begin
                st_q <= scm_pkg::ST_LOOK;
                mem_req_q <= 1'b0;
              end
              scm_pkg::L1_COARSE: begin
                st_q <= scm_pkg::ST_L2;
                mem_addr_q <= {mem_rdata_i[31:scm_pkg::CRS_LO],
                               mva_q[19:scm_pkg::CRS_IDX_LO], 2'b00};
              end
              scm_pkg::L1_FINE: begin
                st_q <= scm_pkg::ST_L2;
                mem_addr_q <= {mem_rdata_i[31:scm_pkg::FIN_LO],
                               mva_q[19:scm_pkg::FIN_IDX_LO], 2'b00};
              end
              scm_pkg::D_FAULT: begin
                st_q <= scm_pkg::ST_IDLE;
                mem_req_q <= 1'b0;
                busy_q <= 1'b0;
              end
            endcase
          end
        end
        scm_pkg::ST_L2: begin
          if (mem_ack_i) begin
            mem_req_q <= 1'b0;
            st_q <= walk_f ? scm_pkg::ST_IDLE : scm_pkg::ST_LOOK;
            busy_q <= !walk_f;
          end
        end
      endcase
    end
  end

  // Single translation entry, filled by the walker
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tlb_v_q <= 1'b0;
      tlb_sz_q <= scm_pkg::SZ_SECTION;
      {tlb_tag_q, tlb_base_q} <= '0;
      tlb_dom_q <= '0;
      tlb_ap_q <= '0;
    end else if (tlb_flush) begin
      tlb_v_q <= 1'b0;
    end else if (l1_ack && dtype == scm_pkg::L1_SECTION) begin
      tlb_v_q <= 1'b1;
      tlb_sz_q <= scm_pkg::SZ_SECTION;
      tlb_tag_q <= mva_q & scm_pkg::MASK_SEC;
      tlb_base_q <= mem_rdata_i & scm_pkg::MASK_SEC;
      tlb_dom_q <= mem_rdata_i[scm_pkg::DOM_HI:scm_pkg::DOM_LO];
      tlb_ap_q <= {4{mem_rdata_i[scm_pkg::SEC_AP_LO +: 2]}};
    end else if (l2_ack && !walk_f) begin
      tlb_v_q <= 1'b1;
      tlb_sz_q <= scm_pkg::scm_size_type'(dtype);
      tlb_tag_q <= mva_q & mask_of(scm_pkg::scm_size_type'(dtype));
      tlb_base_q <= mem_rdata_i & mask_of(scm_pkg::scm_size_type'(dtype));
      tlb_dom_q <= l1dom_q;
      if (dtype == scm_pkg::L2_TINY) begin
        tlb_ap_q <= {4{mem_rdata_i[scm_pkg::TINY_AP_LO +: 2]}};
      end else begin
        tlb_ap_q <= mem_rdata_i[scm_pkg::PG_AP_HI:scm_pkg::PG_AP_LO];
      end
    end
  end

  // Translation answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xl_done_q <= 1'b0;
      xl_abort_q <= 1'b0;
      xl_pa_q <= '0;
    end else if (ce_i) begin
      xl_done_q <= answer;
      xl_abort_q <= walk_f || (answer && mmu_on && deny);
      xl_pa_q <= mmu_on ? (tlb_base_q | (mva_q & ~mask_of(tlb_sz_q))) : mva_q;
    end
  end

  // Fault status word: domain and cause, page variant sets the page bit
  assign fsr_d = {24'h000000, (st_q == scm_pkg::ST_L1) ? 4'h0 : walk_f ? l1dom_q : tlb_dom_q,
                  (walk_f ? scm_pkg::FS_TRANS : dom_f ? scm_pkg::FS_DOM : scm_pkg::FS_PERM)
                  | ((walk_f ? st_q == scm_pkg::ST_L2 : tlb_sz_q != scm_pkg::SZ_SECTION)
                     ? scm_pkg::FS_PAGE : 4'h0)};

  // Fault status and address capture; a fault wins over a same-cycle software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {dfsr_q, ifsr_q, far_q} <= '0;
    end else if (answer && (walk_f || (mmu_on && deny))) begin
      if (fetch_q) begin
        ifsr_q <= fsr_d;
      end else begin
        dfsr_q <= fsr_d;
        far_q <= mva_q;
      end
    end else if (wr_op && loc == scm_pkg::LOC_FSR) begin
      if (op2 == scm_pkg::OP2_INSN) begin
        ifsr_q <= cp_wdata_i;
      end else begin
        dfsr_q <= cp_wdata_i;
      end
    end else if (wr_op && loc == scm_pkg::LOC_FAR) begin
      far_q <= cp_wdata_i;
    end
  end

  // Wishbone slave: control, status and fault address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= '0;
      cp_en_q <= 1'b1;
    end else if (ce_i) begin
      wb_ack_q <= wb_cyc_i && wb_stb_i && !wb_ack_q;
      wb_dat_q <= '0;
      if (wb_cyc_i && wb_stb_i && !wb_ack_q) begin
        if (wb_we_i && wb_sel_i[0] && wb_adr_i[7:0] == scm_pkg::WB_CTRL) begin
          cp_en_q <= wb_dat_i[0];
        end
        unique case (wb_adr_i[7:0])
          scm_pkg::WB_CTRL: wb_dat_q <= {31'h00000000, cp_en_q};
          scm_pkg::WB_STAT: wb_dat_q <= {29'h00000000, busy_q, tlb_v_q, mmu_on};
          scm_pkg::WB_FAR: wb_dat_q <= far_q;
          default: wb_dat_q <= '0;
        endcase
      end
    end
  end

  // Outputs
  assign cp_done_o = cp_done_q;
  assign cp_undef_o = cp_undef_q;
  assign cp_rdata_o = cp_rdata_q;
  assign xl_busy_o = busy_q;
  assign xl_done_o = xl_done_q;
  assign xl_abort_o = xl_abort_q;
  assign xl_pa_o = xl_pa_q;
  assign mem_req_o = mem_req_q;
  assign mem_addr_o = mem_addr_q;
  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_walk_l1;
    ce_i && st_q == scm_pkg::ST_LOOK && mmu_on && !hit;
  endsequence
  a_user_undef: assert property (take && !cp_priv_i |=> cp_undef_o && cp_done_o)
    else $error("user mode transfer not refused");
  a_cdp_undef: assert property (take && !cp_instr_i[scm_pkg::XFER_BIT] |=> cp_undef_o)
    else $error("non-transfer not undefined");
  a_resv_zero: assert property (rd_op && loc == 4'hC |=> cp_rdata_o == 32'h00000000)
    else $error("reserved location read not zero");
  a_ctrl_write: assert property (wr_op && loc == scm_pkg::LOC_CTRL |=> ctrl_q == $past(cp_wdata_i))
    else $error("control write lost");
  a_miss_walk: assert property (s_walk_l1 |=> st_q == scm_pkg::ST_L1 && mem_req_o)
    else $error("miss did not start level one fetch");
  a_l1_index: assert property (st_q == scm_pkg::ST_L1 |-> mem_addr_o[13:2] == mva_q[31:20])
    else $error("level one index wrong");
  a_hit_abort: assert property (ce_i && st_q == scm_pkg::ST_LOOK && mmu_on && hit && deny
    |=> xl_done_o && xl_abort_o)
    else $error("denied hit not aborted");
  a_sec_one: assert property (l1_ack && dtype == scm_pkg::L1_SECTION
    |=> st_q == scm_pkg::ST_LOOK ##1 (!ce_i || xl_done_o || st_q == scm_pkg::ST_L1))
    else $error("section needed a second fetch");
  a_fast_context_switch_logic_map: assert property (ce_i && va_valid_i && !busy_q && va_i[31:scm_pkg::PID_LO] == '0
    |=> mva_q[31:scm_pkg::PID_LO] == $past(pid_q[31:scm_pkg::PID_LO]))
    else $error("context switch mapping wrong");
endmodule // scm_sysctl

// [scm_pkg.sv]
// Constants and types of the system control coprocessor and its MMU
package scm_pkg;
  // Instruction fields
  localparam int COND_HI = 31;
  localparam int COND_LO = 28;
  localparam int FIX_HI = 27;
  localparam int FIX_LO = 24;
  localparam int MEM_HI = 27;
  localparam int MEM_LO = 25;
  localparam int DIR_BIT = 20;
  localparam int CRN_HI = 19;
  localparam int CRN_LO = 16;
  localparam int RD_HI = 15;
  localparam int RD_LO = 12;
  localparam int CPN_HI = 11;
  localparam int CPN_LO = 8;
  localparam int OP2_HI = 7;
  localparam int OP2_LO = 5;
  localparam int XFER_BIT = 4;
  localparam int CRM_HI = 3;
  localparam int CRM_LO = 0;
  localparam logic [3:0] COND_EXT = 4'hF;
  localparam logic [3:0] FIX_XFER = 4'hE;
  localparam logic [2:0] FIX_MEM = 3'h6;
  localparam logic [3:0] CP_NUM = 4'hF;
  localparam logic [3:0] PC_REG = 4'hF;
  // Register locations and selectors
  localparam logic [3:0] LOC_ID = 4'h0;
  localparam logic [3:0] LOC_CTRL = 4'h1;
  localparam logic [3:0] LOC_TTB = 4'h2;
  localparam logic [3:0] LOC_DAC = 4'h3;
  localparam logic [3:0] LOC_FSR = 4'h5;
  localparam logic [3:0] LOC_FAR = 4'h6;
  localparam logic [3:0] LOC_TLBOP = 4'h8;
  localparam logic [3:0] LOC_LOCK = 4'h9;
  localparam logic [3:0] LOC_TLBLK = 4'hA;
  localparam logic [3:0] LOC_PID = 4'hD;
  localparam logic [3:0] LOC_TEST = 4'hF;
  localparam logic [2:0] OP2_ID = 3'h0;
  localparam logic [2:0] OP2_CTYPE = 3'h1;
  localparam logic [2:0] OP2_TCM = 3'h2;
  localparam logic [2:0] OP2_DATA = 3'h0;
  localparam logic [2:0] OP2_INSN = 3'h1;
  localparam logic [2:0] OP2_FAST_CONTEXT_SWITCH_LOGIC = 3'h0;
  localparam logic [2:0] OP2_CTX = 3'h1;
  localparam logic [3:0] CRM_CLOCK = 4'h0;
  localparam logic [3:0] CRM_TCM = 4'h1;
  localparam int CTRL_MMU = 0;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  // Fast context switch: addresses below 32 MB take the process id
  localparam int PID_LO = 25;
  // Translation table layout
  localparam int TTB_LO = 14;
  localparam int L1_IDX_LO = 20;
  localparam int CRS_LO = 10;
  localparam int FIN_LO = 12;
  localparam int CRS_IDX_LO = 12;
  localparam int FIN_IDX_LO = 10;
  localparam int DOM_HI = 8;
  localparam int DOM_LO = 5;
  localparam int SEC_AP_LO = 10;
  localparam int PG_AP_HI = 11;
  localparam int PG_AP_LO = 4;
  localparam int TINY_AP_LO = 4;
  localparam logic [1:0] D_FAULT = 2'h0;
  localparam logic [1:0] L1_COARSE = 2'h1;
  localparam logic [1:0] L1_SECTION = 2'h2;
  localparam logic [1:0] L1_FINE = 2'h3;
  localparam logic [1:0] L2_LARGE = 2'h1;
  localparam logic [1:0] L2_SMALL = 2'h2;
  localparam logic [1:0] L2_TINY = 2'h3;
  typedef enum logic [1:0] {
    SZ_SECTION = 2'b00,
    SZ_LARGE = 2'b01,
    SZ_SMALL = 2'b10,
    SZ_TINY = 2'b11
  } scm_size_type;
  localparam logic [31:0] MASK_SEC = 32'hFFF00000;
  localparam logic [31:0] MASK_LARGE = 32'hFFFF0000;
  localparam logic [31:0] MASK_SMALL = 32'hFFFFF000;
  localparam logic [31:0] MASK_TINY = 32'hFFFFFC00;
  localparam int LARGE_SUB_LO = 14;
  localparam int SMALL_SUB_LO = 10;
  // Domain access and permission codes
  localparam logic [1:0] DOM_NONE = 2'h0;
  localparam logic [1:0] DOM_CLIENT = 2'h1;
  localparam logic [1:0] DOM_MANAGER = 2'h3;
  localparam logic [1:0] AP_NONE = 2'h0;
  localparam logic [1:0] AP_PRIV = 2'h1;
  localparam logic [1:0] AP_URO = 2'h2;
  // Fault status codes, page variant sets bit 1
  localparam logic [3:0] FS_TRANS = 4'h5;
  localparam logic [3:0] FS_DOM = 4'h9;
  localparam logic [3:0] FS_PERM = 4'hD;
  localparam logic [3:0] FS_PAGE = 4'h2;
  // Walker states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOOK = 2'b01,
    ST_L1 = 2'b10,
    ST_L2 = 2'b11
  } scm_state_type;
  // Wishbone map
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_STAT = 8'h04;
  localparam logic [7:0] WB_FAR = 8'h08;
endpackage

// [scm_access_check.sv]
// Domain and permission check for one translated access
`timescale 1ns/100ps
module scm_access_check (
  input wire logic [31:0] dac_i, // Domain access control word
  input wire logic [3:0] dom_i, // Domain of the entry
  input wire logic [1:0] ap_i, // Selected permission pair
  input wire logic priv_i, // Access is privileged
  input wire logic write_i, // Access is a write
  output logic dom_fault_o, // Domain forbids access
  output logic perm_fault_o // Permissions forbid access
);
  logic [1:0] dac;

  // Domain decides whether permissions are consulted
  always_comb begin
    dac = dac_i[{dom_i, 1'b0} +: 2];
    dom_fault_o = (dac != scm_pkg::DOM_CLIENT) && (dac != scm_pkg::DOM_MANAGER);
    perm_fault_o = 1'b0;
    if (dac == scm_pkg::DOM_CLIENT) begin
      unique case (ap_i)
        scm_pkg::AP_NONE: perm_fault_o = 1'b1;
        scm_pkg::AP_PRIV: perm_fault_o = !priv_i;
        scm_pkg::AP_URO: perm_fault_o = !priv_i && write_i;
        default: perm_fault_o = 1'b0;
      endcase
    end
  end
endmodule // scm_access_check

// [scm_mem_model.sv]
// Translation table memory answering the walker's fetches
`timescale 1ns/100ps
module scm_mem_model (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Synchronous reset
  input wire logic req_i, // Fetch request
  input wire logic [31:0] addr_i, // Fetch address
  input wire logic [3:0] dly_i, // Wait cycles before answer
  output logic [31:0] rdata_o, // Descriptor
  output logic ack_o // Fetch done
);
  logic [31:0] mem [logic [31:0]];
  logic [3:0] cnt_q;
  // Answer after dly_i cycles; data is scrambled outside the answer cycle
  always_ff @(posedge clk_i) begin
    ack_o <= 1'h0;
    rdata_o <= rst_i ? 32'h0 : ~rdata_o;
    cnt_q <= 4'h0;
    if (req_i && !ack_o && !rst_i) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == dly_i) begin
        ack_o <= 1'h1;
        rdata_o <= mem[addr_i];
      end
    end
  end
endmodule // scm_mem_model

// [tb.sv]
// Testbench of the coprocessor port, translation port and Wishbone registers
`timescale 1ns/100ps
module tb;
  logic clk_i = 1'h0;
  logic rst_i, cp_valid_i, cp_priv_i, va_valid_i, va_priv_i, wb_cyc_i, wb_we_i, va_wr;
  logic cp_done_o, cp_undef_o, xl_busy_o, xl_done_o, xl_abort_o, mem_req_o, mem_ack_i, wb_ack_o;
  logic [31:0] cp_instr_i, cp_wdata_i, va_i, wb_adr_i, wb_dat_i, cp_rdata_o, xl_pa_o;
  logic [31:0] mem_addr_o, mem_rdata_i, wb_dat_o;
  logic [3:0] dly;
  int mismatches, n_compared;
  scm_sysctl i_dut (.clk_i, .rst_i, .ce_i(1'h1), .cp_valid_i, .cp_instr_i, .cp_wdata_i,
    .cp_priv_i, .cp_done_o, .cp_undef_o, .cp_rdata_o, .va_valid_i, .va_i, .va_write_i(va_wr),
    .va_fetch_i(1'h0), .va_priv_i, .xl_busy_o, .xl_done_o, .xl_abort_o, .xl_pa_o, .mem_req_o,
    .mem_addr_o, .mem_rdata_i, .mem_ack_i, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o);
  scm_mem_model i_mem (.clk_i, .rst_i, .req_i(mem_req_o), .addr_i(mem_addr_o), .dly_i(dly),
    .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
  // Clock of 10 ns
  always #5 clk_i = ~clk_i;
  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Transfer word with core register 1; pc never used
  function automatic logic [31:0] ins(input logic l, input logic [3:0] target_reg_field,
    input logic [2:0] op2, input logic [3:0] aux_reg_field);
    return {4'hE, 4'hE, 3'h0, l, target_reg_field, 4'h1, 4'hF, op2, 1'h1, aux_reg_field};
  endfunction
  // Exp holds undefined flag and read value
  task automatic cp(input logic [31:0] ins, input logic [31:0] wd, input logic pv,
    input logic [32:0] exp);
    @(posedge clk_i);
    cp_valid_i <= 1'h1;
    cp_instr_i <= ins;
    cp_wdata_i <= wd;
    cp_priv_i <= pv;
    @(posedge clk_i);
    cp_valid_i <= 1'h0;
    @(posedge clk_i);
    chk({cp_done_o, cp_undef_o, cp_rdata_o}, {1'h1, exp});
  endtask
  // Exp holds abort flag and physical address
  task automatic xl(input logic [31:0] va, input logic pv, input logic [32:0] exp);
    @(posedge clk_i);
    va_valid_i <= 1'h1;
    va_i <= va;
    va_priv_i <= pv;
    @(posedge clk_i);
    va_valid_i <= 1'h0;
    @(posedge clk_i);
    chk(xl_busy_o, 34'h1);
    do @(posedge clk_i); while (xl_done_o !== 1'h1);
    chk(xl_busy_o, 34'h0);
    chk({xl_done_o, xl_abort_o, exp[32] ? 32'h0 : xl_pa_o}, {1'h1, exp});
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    chk({1'h0, wb_ack_o, we ? d : wb_dat_o}, {2'h1, d});
    wb_cyc_i <= 1'h0;
  endtask
  // Main sequence
  initial begin
    {rst_i, cp_valid_i, cp_priv_i, va_valid_i, va_priv_i, wb_cyc_i, wb_we_i, va_wr} = 8'h80;
    {cp_instr_i, cp_wdata_i, va_i, wb_adr_i, wb_dat_i} = '0;
    dly = 4'h0;
    i_mem.mem[32'h4400] = 32'h20000C02;
    i_mem.mem[32'h4C00] = 32'h30000402;
    i_mem.mem[32'h5400] = 32'h00008001;
    i_mem.mem[32'h800C] = 32'h40000FF2;
    i_mem.mem[32'h8070] = 32'h700003F1;
    i_mem.mem[32'h4084] = 32'h60000C02;
    i_mem.mem[32'h4800] = 32'h80000802;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, 8'h00, 32'h1);
    wb(1'h0, 8'h40, 32'h0);
    cp(ins(1'h0, 4'h2, 3'h0, 4'h0), 32'h4000, 1'h1, 33'h0);
    cp(ins(1'h1, 4'h2, 3'h0, 4'h0), 32'h0, 1'h1, 33'h4000);
    cp(ins(1'h1, 4'h2, 3'h0, 4'h0), 32'h0, 1'h0, 33'h100000000);
    cp(ins(1'h1, 4'h2, 3'h0, 4'h0) & ~32'h10, 32'h0, 1'h1, 33'h100000000);
    cp(ins(1'h1, 4'h2, 3'h0, 4'h0) ^ 32'h02000000, 32'h0, 1'h1, 33'h100000000);
    cp(ins(1'h1, 4'h2, 3'h0, 4'h0) | 32'hF0000000, 32'h0, 1'h1, 33'h100000000);
    cp(ins(1'h1, 4'h2, 3'h0, 4'h0) ^ 32'h00000100, 32'h0, 1'h1, 33'h100000000);
    cp(ins(1'h1, 4'hC, 3'h0, 4'h0), 32'h0, 1'h1, 33'h0);
    cp(ins(1'h0, 4'h4, 3'h0, 4'h0), 32'hFFFF, 1'h1, 33'h0);
    cp(ins(1'h1, 4'h4, 3'h0, 4'h0), 32'h0, 1'h1, 33'h0);
    cp(ins(1'h0, 4'hD, 3'h1, 4'h0), 32'h55, 1'h1, 33'h0);
    cp(ins(1'h0, 4'h9, 3'h0, 4'h1), 32'h1, 1'h1, 33'h0);
    cp(ins(1'h0, 4'h9, 3'h0, 4'h0), 32'h0, 1'h1, 33'h0);
    cp(ins(1'h1, 4'h9, 3'h0, 4'h1), 32'h0, 1'h1, 33'h1);
    wb(1'h1, 8'h00, 32'h0);
    cp(ins(1'h1, 4'h2, 3'h0, 4'h0), 32'h0, 1'h1, 33'h100000000);
    wb(1'h1, 8'h00, 32'h1);
    cp(ins(1'h0, 4'h3, 3'h0, 4'h0), 32'h1, 1'h1, 33'h0);
    cp(ins(1'h0, 4'h1, 3'h0, 4'h0), 32'h1, 1'h1, 33'h0);
    xl(32'h10012345, 1'h1, 33'h20012345);
    dly <= 4'h3;
    xl(32'h10012345, 1'h0, 33'h20012345);
    xl(32'h30000000, 1'h0, 33'h100000000);
    xl(32'h50003456, 1'h1, 33'h40000456);
    xl(32'h5001C010, 1'h1, 33'h100000000);
    xl(32'h50018010, 1'h1, 33'h70008010);
    wb(1'h0, 8'h08, 32'h5001C010);
    cp(ins(1'h1, 4'h5, 3'h0, 4'h0), 32'h0, 1'h1, 33'hF);
    va_wr <= 1'h1;
    xl(32'h20000010, 1'h0, 33'h100000000);
    va_wr <= 1'h0;
    xl(32'h20000010, 1'h0, 33'h80000010);
    cp(ins(1'h0, 4'hD, 3'h0, 4'h0), 32'h02000000, 1'h1, 33'h0);
    cp(ins(1'h1, 4'hD, 3'h1, 4'h0), 32'h0, 1'h1, 33'h55);
    xl(32'h00100000, 1'h1, 33'h60000000);
    wb(1'h0, 8'h04, 32'h3);
    cp(ins(1'h0, 4'h8, 3'h0, 4'h0), 32'h0, 1'h1, 33'h0);
    wb(1'h0, 8'h04, 32'h1);
    finish_test();
  end
  // Watchdog against a hang
  initial begin
    #20000;
    mismatches++;
    finish_test();
  end
endmodule // tb
